// ===== dcw_map.svh
// Bit positions, widths and reset values of the drive command word decoder
`ifndef DCW_MAP_SVH
`define DCW_MAP_SVH

`define DCW_WORD_W 32
`define DCW_PASS_W 16
`define DCW_USER_W 4

`define DCW_BIT_STOP 0
`define DCW_BIT_START 1
`define DCW_BIT_REVERSE 2
`define DCW_BIT_FAULT_RESET 4
`define DCW_BIT_EXT_LOC 5
`define DCW_BIT_RUN_DISABLE 6
`define DCW_BIT_STOP_NORMAL 7
`define DCW_BIT_STOP_FAST 8
`define DCW_BIT_STOP_FREEWHEEL 9
`define DCW_BIT_RAMP_OUT_ZERO 11
`define DCW_BIT_RAMP_HOLD 12
`define DCW_BIT_RAMP_IN_ZERO 13
`define DCW_BIT_TAKE_CTL 16
`define DCW_BIT_TAKE_REF 17
`define DCW_USER_LSB 22
`define DCW_USER_MSB 25
`define DCW_RESERVED_MASK 32'hFC3C_8408

`define DCW_RST_WORD 32'h0000_0000
`define DCW_RST_USER 4'h0
`define DCW_RST_MODE 2'h0

`endif

// ===== dcw_pkg.sv
// Types shared by the drive command word decoder
package dcw_pkg;

  typedef enum logic [1:0]
  {
    DCW_STOP_NORMAL_RAMP = 2'h0,
    DCW_STOP_FAST_RAMP = 2'h1,
    DCW_STOP_FREEWHEEL = 2'h2
  } dcw_stop_mode_e;

  typedef logic [31:0] dcw_word_t;

endpackage

// ===== dcw_stop_if.sv
// Carrier between the decoder and its stop-mode resolver
`timescale 1ns/1ps
interface dcw_stop_if;
  import dcw_pkg::*;
  logic sel_normal;
  logic sel_fast;
  logic sel_freewheel;
  dcw_stop_mode_e param_mode;
  dcw_stop_mode_e mode;
  logic from_param;

  modport decoder (output sel_normal, output sel_fast, output sel_freewheel,
    output param_mode, input mode, input from_param);
  modport resolver (input sel_normal, input sel_fast, input sel_freewheel,
    input param_mode, output mode, output from_param);
endinterface

// ===== dcw_stop_resolve.sv
// Stop-mode selection from the command bits with parameter fallback
`timescale 1ns/1ps
module dcw_stop_resolve
  import dcw_pkg::*;
(
  // Request bits in, chosen mode out
  dcw_stop_if.resolver sif
);

  wire none_set;

  assign none_set = ~(sif.sel_normal | sif.sel_fast | sif.sel_freewheel);
  assign sif.from_param = none_set;

  // Several bits at once: the harshest stop wins, so a coast request is never softened
  assign sif.mode = none_set ? sif.param_mode :
    sif.sel_freewheel ? DCW_STOP_FREEWHEEL :
    sif.sel_fast ? DCW_STOP_FAST_RAMP :
    DCW_STOP_NORMAL_RAMP;

endmodule // dcw_stop_resolve

// ===== dcw_decoder.sv
// Fieldbus command word decoder for the alternate command profile
`timescale 1ns/1ps
`include "dcw_map.svh"
module dcw_decoder
  import dcw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fieldbus command word write
  input wire logic [31:0] cmd_wdata,
  input wire logic cmd_wr,
  // Drive parameters and drive state
  input wire dcw_stop_mode_e stop_mode_param,
  input wire logic loc_sel_from_bus,
  input wire logic run_enable_from_bus,
  input wire logic fault_active,
  // Internal drive control word
  output logic [31:0] drive_ctrl_word,
  // Decoded commands
  output logic stop_req,
  output dcw_stop_mode_e stop_mode,
  output logic stop_mode_from_param,
  output logic start_req,
  output logic reverse_req,
  output logic fault_reset,
  output logic external_location_two_select,
  output logic run_enable,
  output logic ramp_out_zero,
  output logic ramp_hold,
  output logic ramp_in_zero,
  output logic bus_takeover_control,
  output logic bus_takeover_reference,
  output logic [3:0] user_bits
);

  dcw_word_t fieldbus_command_word_r;
  dcw_word_t word_nxt;
  logic fault_bit_prev_r;
  logic [31:0] drive_ctrl_word_r;
  logic stop_req_r;
  dcw_stop_mode_e stop_mode_r;
  logic from_param_r;
  logic start_req_r;
  logic reverse_req_r;
  logic fault_reset_r;
  logic loc_two_r;
  logic run_enable_r;
  logic ramp_out_zero_r;
  logic ramp_hold_r;
  logic ramp_in_zero_r;
  logic take_ctl_r;
  logic take_ref_r;
  logic [3:0] user_bits_r;

  wire fault_edge;
  wire loc_two_nxt;
  wire run_enable_nxt;
  wire [31:0] pass_nxt;

  dcw_stop_if sif ();

  // Latest word from the bus; held between writes
  assign word_nxt = cmd_wr ? cmd_wdata : fieldbus_command_word_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      fieldbus_command_word_r <= `DCW_RST_WORD;
    else
      fieldbus_command_word_r <= word_nxt;
  end

  // Only the low half is carried; the upper half is left at zero on purpose
  assign pass_nxt = {{(`DCW_WORD_W - `DCW_PASS_W){1'b0}},
    fieldbus_command_word_r[`DCW_PASS_W-1:0]};

  assign sif.sel_normal = fieldbus_command_word_r[`DCW_BIT_STOP_NORMAL];
  assign sif.sel_fast = fieldbus_command_word_r[`DCW_BIT_STOP_FAST];
  assign sif.sel_freewheel = fieldbus_command_word_r[`DCW_BIT_STOP_FREEWHEEL];
  assign sif.param_mode = stop_mode_param;

  dcw_stop_resolve u_stop_resolve
  (
    .sif(sif.resolver)
  );

  // Rising edge of bit 4 against last cycle; acts only with a fault present
  assign fault_edge = fieldbus_command_word_r[`DCW_BIT_FAULT_RESET] & ~fault_bit_prev_r &
    fault_active;

  // Bus only steers location and run enable when the parameters route them here
  assign loc_two_nxt = loc_sel_from_bus & fieldbus_command_word_r[`DCW_BIT_EXT_LOC];
  assign run_enable_nxt = ~run_enable_from_bus |
    ~fieldbus_command_word_r[`DCW_BIT_RUN_DISABLE];

  always_ff @(posedge clk)
  begin
    if (rst)
      fault_bit_prev_r <= 1'b0;
    else
      fault_bit_prev_r <= fieldbus_command_word_r[`DCW_BIT_FAULT_RESET];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive_ctrl_word_r <= `DCW_RST_WORD;
      stop_req_r <= 1'b0;
      stop_mode_r <= dcw_stop_mode_e'(`DCW_RST_MODE);
      from_param_r <= 1'b1;
      start_req_r <= 1'b0;
      reverse_req_r <= 1'b0;
    end
    else
    begin
      drive_ctrl_word_r <= pass_nxt;
      stop_req_r <= fieldbus_command_word_r[`DCW_BIT_STOP];
      stop_mode_r <= sif.mode;
      from_param_r <= sif.from_param;
      start_req_r <= fieldbus_command_word_r[`DCW_BIT_START];
      reverse_req_r <= fieldbus_command_word_r[`DCW_BIT_REVERSE];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fault_reset_r <= 1'b0;
      loc_two_r <= 1'b0;
      run_enable_r <= 1'b1;
      ramp_out_zero_r <= 1'b0;
      ramp_hold_r <= 1'b0;
      ramp_in_zero_r <= 1'b0;
    end
    else
    begin
      fault_reset_r <= fault_edge;
      loc_two_r <= loc_two_nxt;
      run_enable_r <= run_enable_nxt;
      ramp_out_zero_r <= fieldbus_command_word_r[`DCW_BIT_RAMP_OUT_ZERO];
      ramp_hold_r <= fieldbus_command_word_r[`DCW_BIT_RAMP_HOLD];
      ramp_in_zero_r <= fieldbus_command_word_r[`DCW_BIT_RAMP_IN_ZERO];
    end
  end

  // Reserved positions have no register here, but reserved bits 3, 10 and 15 still reach drive_ctrl_word through the low half
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      take_ctl_r <= 1'b0;
      take_ref_r <= 1'b0;
      user_bits_r <= `DCW_RST_USER;
    end
    else
    begin
      take_ctl_r <= fieldbus_command_word_r[`DCW_BIT_TAKE_CTL];
      take_ref_r <= fieldbus_command_word_r[`DCW_BIT_TAKE_REF];
      user_bits_r <= fieldbus_command_word_r[`DCW_USER_MSB:`DCW_USER_LSB];
    end
  end

  assign drive_ctrl_word = drive_ctrl_word_r;
  assign stop_req = stop_req_r;
  assign stop_mode = stop_mode_r;
  assign stop_mode_from_param = from_param_r;
  assign start_req = start_req_r;
  assign reverse_req = reverse_req_r;
  assign fault_reset = fault_reset_r;
  assign external_location_two_select = loc_two_r;
  assign run_enable = run_enable_r;
  assign ramp_out_zero = ramp_out_zero_r;
  assign ramp_hold = ramp_hold_r;
  assign ramp_in_zero = ramp_in_zero_r;
  assign bus_takeover_control = take_ctl_r;
  assign bus_takeover_reference = take_ref_r;
  assign user_bits = user_bits_r;

  // Checks on the decoder outputs, two cycles from the write to the command
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic past_ok_r;

  always_ff @(posedge clk)
  begin
    if (rst)
      past_ok_r <= 1'b0;
    else
      past_ok_r <= 1'b1;
  end

  chk_pass_low_half: assert property (
    cmd_wr ##1 !cmd_wr |=> drive_ctrl_word[15:0] == $past(cmd_wdata[15:0], 2))
    else $error("Low half of drive word differs from written word");

  chk_upper_half_zero: assert property (
    drive_ctrl_word[31:16] == 16'h0000)
    else $error("Upper half of drive word is not zero");

  chk_stop_follow: assert property (
    cmd_wr ##1 !cmd_wr |=> stop_req == $past(cmd_wdata[0], 2))
    else $error("Stop request does not follow bit 0");

  chk_start_reverse: assert property (
    cmd_wr ##1 !cmd_wr |=> start_req == $past(cmd_wdata[1], 2) &&
      reverse_req == $past(cmd_wdata[2], 2))
    else $error("Start or reverse does not follow its bit");

  chk_fault_reset_cause: assert property (
    fault_reset |-> past_ok_r && $past(fieldbus_command_word_r[4]) &&
      !$past(fieldbus_command_word_r[4], 2) && $past(fault_active))
    else $error("Fault reset without a rising bit 4 and active fault");

  chk_fault_reset_single: assert property (
    fault_reset |=> !fault_reset)
    else $error("Fault reset lasted more than one cycle");

  chk_fault_reset_fires: assert property (
    fieldbus_command_word_r[4] && !fault_bit_prev_r && fault_active |=> fault_reset)
    else $error("Rising bit 4 with fault gave no reset");

  chk_location_gate: assert property (
    external_location_two_select |-> $past(loc_sel_from_bus) &&
      $past(fieldbus_command_word_r[5]))
    else $error("Location two selected without routing and bit 5");

  chk_run_disable: assert property (
    run_enable_from_bus && fieldbus_command_word_r[6] |=> !run_enable)
    else $error("Run enable kept while bit 6 disables it");

  chk_run_local: assert property (
    !run_enable_from_bus |=> run_enable)
    else $error("Run enable dropped while not routed to the bus");

  chk_mode_coast: assert property (
    fieldbus_command_word_r[9] |=> stop_mode == DCW_STOP_FREEWHEEL && !stop_mode_from_param)
    else $error("Coast bit did not select coast mode");

  chk_mode_fast: assert property (
    fieldbus_command_word_r[9:8] == 2'h1 |=> stop_mode == DCW_STOP_FAST_RAMP)
    else $error("Emergency bit did not select fast ramp");

  chk_mode_normal: assert property (
    fieldbus_command_word_r[9:7] == 3'h1 |=> stop_mode == DCW_STOP_NORMAL_RAMP)
    else $error("Normal bit did not select normal ramp");

  chk_mode_param: assert property (
    fieldbus_command_word_r[9:7] == 3'h0 |=> stop_mode == $past(stop_mode_param) &&
      stop_mode_from_param)
    else $error("Parameter stop mode not used with no mode bits");

  chk_ramp_controls: assert property (
    past_ok_r |-> ramp_out_zero == $past(fieldbus_command_word_r[11]) &&
      ramp_hold == $past(fieldbus_command_word_r[12]) &&
      ramp_in_zero == $past(fieldbus_command_word_r[13]))
    else $error("Ramp control outputs do not follow bits 11 to 13");

  chk_takeover: assert property (
    cmd_wr ##1 !cmd_wr |=> bus_takeover_control == $past(cmd_wdata[16], 2) &&
      bus_takeover_reference == $past(cmd_wdata[17], 2))
    else $error("Takeover requests do not follow bits 16 and 17");

  chk_user_bits: assert property (
    cmd_wr ##1 !cmd_wr |=> user_bits == $past(cmd_wdata[25:22], 2))
    else $error("User bits do not follow bits 22 to 25");

  // A word holding only reserved bits must leave every command at rest
  chk_reserved_quiet: assert property (
    cmd_wr && (cmd_wdata & ~`DCW_RESERVED_MASK) == 32'h0000_0000 ##1 !cmd_wr |=>
      !stop_req && !start_req && !reverse_req && !fault_reset &&
      !external_location_two_select && run_enable && stop_mode_from_param &&
      !ramp_out_zero && !ramp_hold && !ramp_in_zero && !bus_takeover_control &&
      !bus_takeover_reference && user_bits == 4'h0 && drive_ctrl_word[31:16] == 16'h0000)
    else $error("Reserved bits produced a command");

  chk_word_store: assert property (
    cmd_wr |=> fieldbus_command_word_r == $past(cmd_wdata))
    else $error("Written word was not stored");

  chk_copy_each_cycle: assert property (
    past_ok_r |-> drive_ctrl_word[15:0] == $past(fieldbus_command_word_r[15:0]))
    else $error("Drive word low half does not track the stored word");

  chk_stop_level: assert property (
    past_ok_r |-> stop_req == $past(fieldbus_command_word_r[0]))
    else $error("Stop request does not track stored bit 0");

  chk_start_rev_level: assert property (
    past_ok_r |-> start_req == $past(fieldbus_command_word_r[1]) &&
      reverse_req == $past(fieldbus_command_word_r[2]))
    else $error("Start or reverse does not track its stored bit");

  chk_fault_gate: assert property (
    !fault_active |=> !fault_reset)
    else $error("Fault reset issued with no active fault");

  chk_held_one_quiet: assert property (
    fieldbus_command_word_r[4] && fault_bit_prev_r |=> !fault_reset)
    else $error("Held bit 4 triggered a fault reset again");

  chk_location_follow: assert property (
    loc_sel_from_bus |=>
      external_location_two_select == $past(fieldbus_command_word_r[5]))
    else $error("Routed location does not follow bit 5");

  chk_location_local: assert property (
    !loc_sel_from_bus |=> !external_location_two_select)
    else $error("Location two selected while not routed to the bus");

  chk_run_enable_bus: assert property (
    run_enable_from_bus && !fieldbus_command_word_r[6] |=> run_enable)
    else $error("Run enable missing while bit 6 is clear");

  chk_mode_bits_used: assert property (
    fieldbus_command_word_r[9:7] != 3'h0 |=> !stop_mode_from_param)
    else $error("Parameter stop mode used although a mode bit is set");

  chk_takeover_level: assert property (
    past_ok_r |-> bus_takeover_control == $past(fieldbus_command_word_r[16]) &&
      bus_takeover_reference == $past(fieldbus_command_word_r[17]))
    else $error("Takeover outputs do not track stored bits 16 and 17");

  chk_user_level: assert property (
    past_ok_r |-> user_bits == $past(fieldbus_command_word_r[25:22]))
    else $error("User bits do not track stored bits 22 to 25");

  cov_fault_reset: cover property (fault_active ##1 fault_reset);
  cov_stop_coast: cover property (stop_req && stop_mode == DCW_STOP_FREEWHEEL);
  cov_stop_param: cover property (stop_req && stop_mode_from_param);
  cov_run_disable: cover property (run_enable_from_bus ##1 !run_enable);

endmodule // dcw_decoder

// ===== dcw_bus_master.sv
// Fieldbus master model that writes the drive command word
`timescale 1ns/1ps
module dcw_bus_master
(
  // Clock
  input wire logic clk,
  // Command word write
  output logic [31:0] cmd_wdata,
  output logic cmd_wr
);
  initial
  begin
    cmd_wdata = 32'h0;
    cmd_wr = 1'h0;
  end

  // One-cycle write; idle data shows the inverse so stale words never look valid
  task automatic write(input logic [31:0] w);
    @(negedge clk);
    cmd_wdata = w;
    cmd_wr = 1'h1;
    @(negedge clk);
    cmd_wr = 1'h0;
    cmd_wdata = ~w;
  endtask
endmodule // dcw_bus_master

// ===== dcw_decoder_test.sv
// Self-checking testbench for the drive command word decoder
`timescale 1ns/1ps
module dcw_decoder_test;
  import dcw_pkg::*;
  logic clk, rst, loc_sel_from_bus, run_enable_from_bus, fault_active;
  dcw_stop_mode_e stop_mode_param, stop_mode;
  logic [31:0] cmd_wdata, drive_ctrl_word;
  logic cmd_wr, stop_req, stop_mode_from_param, start_req, reverse_req, fault_reset;
  logic external_location_two_select, run_enable, ramp_out_zero, ramp_hold, ramp_in_zero;
  logic bus_takeover_control, bus_takeover_reference;
  logic [3:0] user_bits;
  logic [13:0] cmds;
  int errors, cmp_count, cycles, pulses;

  assign cmds = {user_bits, bus_takeover_reference, bus_takeover_control, ramp_in_zero,
    ramp_hold, ramp_out_zero, run_enable, external_location_two_select, reverse_req,
    start_req, stop_req};

  dcw_bus_master bus_u (.clk, .cmd_wdata, .cmd_wr);

  dcw_decoder dut_u (.clk, .rst, .cmd_wdata, .cmd_wr, .stop_mode_param, .loc_sel_from_bus,
    .run_enable_from_bus, .fault_active, .drive_ctrl_word, .stop_req, .stop_mode,
    .stop_mode_from_param, .start_req, .reverse_req, .fault_reset,
    .external_location_two_select, .run_enable, .ramp_out_zero, .ramp_hold, .ramp_in_zero,
    .bus_takeover_control, .bus_takeover_reference, .user_bits);

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Pulses are counted at the edge so a one-cycle pulse cannot be missed
  always @(posedge clk)
  begin
    cycles++;
    if (fault_reset === 1'h1)
      pulses++;
    if (cycles == 2000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Allows for the decode latency before outputs are judged
  task automatic put(input logic [31:0] w);
    bus_u.write(w);
    repeat (2) @(negedge clk);
  endtask

  task automatic reset_values();
    chk(drive_ctrl_word, 32'h0);
    chk({14'h0, stop_mode_from_param, stop_mode, fault_reset, cmds}, 32'h0002_0010);
  endtask

  task automatic walk_bits();
    logic [13:0] e;
    loc_sel_from_bus = 1'h1;
    run_enable_from_bus = 1'h1;
    for (int i = 0; i < 32; i++)
    begin
      e = 14'h0010;
      case (i)
        0, 1, 2: e[i] = 1'h1;
        5: e[3] = 1'h1;
        6: e[4] = 1'h0;
        11, 12, 13: e[i - 6] = 1'h1;
        16, 17: e[i - 8] = 1'h1;
        22, 23, 24, 25: e[i - 12] = 1'h1;
        default: ;
      endcase
      put(32'h1 << i);
      chk(drive_ctrl_word, (32'h1 << i) & 32'h0000_FFFF);
      chk({18'h0, cmds}, {18'h0, e});
    end
  endtask

  task automatic routing();
    put(32'hFFFF_FFFF);
    chk(drive_ctrl_word, 32'h0000_FFFF);
    chk({18'h0, cmds}, 32'h0000_3FEF);
    chk({29'h0, stop_mode_from_param, stop_mode}, 32'h2);
    loc_sel_from_bus = 1'h0;
    run_enable_from_bus = 1'h0;
    repeat (2) @(negedge clk);
    chk({18'h0, cmds}, 32'h0000_3FF7);
  endtask

  task automatic stop_modes();
    logic [1:0] e;
    for (int p = 0; p < 3; p++)
      for (int m = 0; m < 8; m++)
      begin
        stop_mode_param = dcw_stop_mode_e'(p);
        e = m[2] ? 2'h2 : m[1] ? 2'h1 : m[0] ? 2'h0 : 2'(p);
        put({22'h0, 3'(m), 7'h01});
        chk({29'h0, stop_mode_from_param, stop_mode}, {29'h0, (m == 0), e});
        chk({31'h0, stop_req}, 32'h1);
      end
  endtask

  task automatic fault_edges();
    fault_active = 1'h1;
    put(32'h0);
    pulses = 0;
    put(32'h10);
    @(negedge clk);
    chk(pulses, 32'h1);
    pulses = 0;
    put(32'h10);
    @(negedge clk);
    chk(pulses, 32'h0);
    put(32'h0);
    fault_active = 1'h0;
    pulses = 0;
    put(32'h10);
    @(negedge clk);
    chk(pulses, 32'h0);
  endtask

  initial
  begin
    rst = 1'h1;
    loc_sel_from_bus = 1'h0;
    run_enable_from_bus = 1'h0;
    fault_active = 1'h0;
    stop_mode_param = DCW_STOP_NORMAL_RAMP;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    pulses = 0;
    repeat (4) @(negedge clk);
    reset_values();
    rst = 1'h0;
    walk_bits();
    routing();
    stop_modes();
    fault_edges();
    print_verdict();
  end
endmodule // dcw_decoder_test
